/* File: src/gpp_map.svh */
// register offsets, field layouts, reset values and mode codes of the gpio port
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define GPP_OFS_DRIVE 9'h000
`define GPP_OFS_MODE_LOW 9'h004
`define GPP_OFS_MODE_HIGH 9'h008
`define GPP_OFS_LATCH 9'h00c
`define GPP_OFS_SET 9'h010
`define GPP_OFS_CLEAR 9'h014
`define GPP_OFS_TOGGLE 9'h018
`define GPP_OFS_INPUT 9'h01c
`define GPP_OFS_UNLOCK 9'h020
`define GPP_OFS_IRQ_SEL 9'h100

// ----------------------------------------------------------------
// widths and field positions
// ----------------------------------------------------------------
`define GPP_PINS 16
`define GPP_PORTS 6
`define GPP_LINES 8
`define GPP_MODE_W 4
`define GPP_SEL_W 3
`define GPP_DRIVE_W 2
`define GPP_IRQ_SEL_MASK 32'h77777777

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPP_RST_MODE 32'h00000000
`define GPP_RST_LATCH 16'h0000
`define GPP_RST_INPUT 16'h0000
`define GPP_RST_UNLOCK 16'hffff
`define GPP_RST_IRQ_SEL 32'h00000000
`define GPP_RST_DRIVE 2'h0

// ----------------------------------------------------------------
// pin mode codes and the highest irq port select code
// ----------------------------------------------------------------
`define GPP_M_DISABLED 4'h0
`define GPP_M_INPUT 4'h1
`define GPP_M_INPUT_PULL 4'h2
`define GPP_M_INPUT_PULLED_FILTERED 4'h3
`define GPP_M_PUSH_PULL 4'h4
`define GPP_M_PUSH_PULL_ALT 4'h5
`define GPP_M_WIRED_OR 4'h6
`define GPP_M_WIRED_OR_PULLDOWN 4'h7
`define GPP_M_OPEN_DRAIN 4'h8
`define GPP_M_OPEN_DRAIN_ALT 4'hc
`define GPP_SEL_MAX 3'h5

`endif

/* File: src/gpp_pkg.sv */
// types shared by the gpio port pin configuration logic
package gpp_pkg;

  // per-pin pad control bundle
  typedef struct packed {
    logic in_en;   // input sense enabled
    logic out;     // level to drive
    logic oe;      // pad driver enabled
    logic pull_en; // pull resistor on
    logic pull_up; // pull direction, 1 = up
    logic filter;  // input glitch filter on
    logic alt;     // use port-wide drive strength
  } gpp_pin_s;

  typedef logic [3:0] gpp_mode_t;

endpackage

/* File: src/gpp_port.sv */
// gpio port: pin modes, output latch with set/clear/toggle, input, lock, irq select
`timescale 1ns/1ps
`include "gpp_map.svh"

// How it works
// (RQ1) each pin has a 4-bit mode, pins 0-7 low register, 8-15 high, reset zero
// (RQ2) mode 0 disables input; pull-up only while the pin's latch bit is one
// (RQ3) mode 1 enables input; filter only while the pin's latch bit is one
// (RQ4) modes 2 and 3 pull in the latch bit's direction; mode 3 adds filter
// (RQ5) modes 4 and 5 drive push-pull; mode 5 uses the port drive strength
// (RQ6) modes 6 and 7 drive only high; mode 7 adds a pull-down
// (RQ7) modes 8-15 open-drain; bit0 filter, bit1 pull-up, bit2 port strength
// (RQ8) sixteen-bit output latch, read and write, reset zero, upper bits zero
// (RQ9) writing ones to the set port sets those latch bits only
// (RQ10) writing ones to the clear port clears those latch bits only
// (RQ11) writing ones to the toggle port inverts those latch bits only
// (RQ12) input register shows sampled pin levels, read only, reset zero
// (RQ13) unlocked mask resets to ones; clearing a bit locks that pin until reset
// (RQ14) a cleared unlocked bit cannot be set again by software
// (RQ15) eight 3-bit irq port selects at nibble spacing; 0-4 pick ports A-E
// (RQ16) irq port select value 5 picks port F
// (RQ17) software writes zero to reserved bits
module gpp_port
  import gpp_pkg::*;
(
  input wire logic core_clk, // 100 MHz clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [8:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [15:0] pad_in, // pin levels
  input wire logic [95:0] ext_port_levels, // ports A..F, 16 each
  output gpp_pin_s [15:0] pin_ctrl, // pad control per pin
  output logic [1:0] port_drive_strength, // port-wide strength
  output logic [7:0] ext_irq_src // selected irq pin levels
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] pin_mode_low;
  logic [31:0] pin_mode_high;
  logic [15:0] output_latch;
  logic [15:0] pin_input_value;
  logic [15:0] unlocked_pins;
  logic [31:0] ext_irq_port_low;
  logic [31:0] next_readdata;
  logic [31:0] keep_low;
  logic [31:0] keep_high;
  logic [63:0] all_modes;
  logic [15:0] next_in_en;
  logic [7:0] next_irq;
  logic wr_take;
  logic rd_first;
  gpp_pin_s [15:0] next_pin;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------

  // access lands on the edge where waitrequest is low
  assign wr_take = avs_write && !avs_waitrequest;
  assign rd_first = avs_read && avs_waitrequest;

  // one wait cycle per access, then release
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // read data mux, reserved and unmapped read zero
  always_comb
  begin
    next_readdata = 32'h00000000;
    case (avs_address)
      `GPP_OFS_DRIVE:
        next_readdata = {30'h00000000, port_drive_strength};
      `GPP_OFS_MODE_LOW:
        next_readdata = pin_mode_low; // RQ1
      `GPP_OFS_MODE_HIGH:
        next_readdata = pin_mode_high; // RQ1
      `GPP_OFS_LATCH:
        next_readdata = {16'h0000, output_latch}; // RQ8
      `GPP_OFS_INPUT:
        next_readdata = {16'h0000, pin_input_value}; // RQ12
      `GPP_OFS_UNLOCK:
        next_readdata = {16'h0000, unlocked_pins}; // RQ13
      `GPP_OFS_IRQ_SEL:
        next_readdata = ext_irq_port_low; // RQ15
      default:
        next_readdata = 32'h00000000;
    endcase
  end

  // read data captured in the wait cycle, valid when waitrequest drops
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      avs_readdata <= 32'h00000000;
    else if (rd_first)
      avs_readdata <= next_readdata;
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------

  // port-wide drive strength
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      port_drive_strength <= `GPP_RST_DRIVE;
    else if (wr_take && avs_address == `GPP_OFS_DRIVE)
      port_drive_strength <= avs_writedata[1:0];
  end

  // nibble keep masks from the lock bits
  genvar gk;
  generate
    for (gk = 0; gk < 8; gk++)
    begin : g_keep
      assign keep_low[4*gk+:4] = {4{~unlocked_pins[gk]}}; // RQ13
      assign keep_high[4*gk+:4] = {4{~unlocked_pins[gk+8]}}; // RQ13
    end
  endgenerate

  // low pin modes, locked fields hold
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pin_mode_low <= `GPP_RST_MODE; // RQ1
    else if (wr_take && avs_address == `GPP_OFS_MODE_LOW)
      pin_mode_low <= (avs_writedata & ~keep_low) | (pin_mode_low & keep_low); // RQ13
  end

  // high pin modes, locked fields hold
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pin_mode_high <= `GPP_RST_MODE; // RQ1
    else if (wr_take && avs_address == `GPP_OFS_MODE_HIGH)
      pin_mode_high <= (avs_writedata & ~keep_high) | (pin_mode_high & keep_high); // RQ13
  end

  // output latch and its set, clear and toggle ports
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      output_latch <= `GPP_RST_LATCH; // RQ8
    else if (wr_take)
    begin
      case (avs_address)
        `GPP_OFS_LATCH:
          output_latch <= avs_writedata[15:0]; // RQ8
        `GPP_OFS_SET:
          output_latch <= output_latch | avs_writedata[15:0]; // RQ9
        `GPP_OFS_CLEAR:
          output_latch <= output_latch & ~avs_writedata[15:0]; // RQ10
        `GPP_OFS_TOGGLE:
          output_latch <= output_latch ^ avs_writedata[15:0]; // RQ11
        default:
          output_latch <= output_latch;
      endcase
    end
  end

  // lock mask only ever loses ones until reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      unlocked_pins <= `GPP_RST_UNLOCK; // RQ13
    else if (wr_take && avs_address == `GPP_OFS_UNLOCK)
      unlocked_pins <= unlocked_pins & avs_writedata[15:0]; // RQ14
  end

  // irq port selects, reserved nibble tops forced to zero
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ext_irq_port_low <= `GPP_RST_IRQ_SEL; // RQ15
    else if (wr_take && avs_address == `GPP_OFS_IRQ_SEL)
      ext_irq_port_low <= avs_writedata & `GPP_IRQ_SEL_MASK; // RQ15
  end

  // ----------------------------------------------------------------
  // pin mode decode
  // ----------------------------------------------------------------

  // maps one mode and latch bit onto pad controls
  function automatic gpp_pin_s pin_decode(input gpp_mode_t m, input logic d);
    gpp_pin_s c;
    c = '0;
    case (m)
      `GPP_M_DISABLED:
      begin
        c.pull_en = d; // RQ2
        c.pull_up = 1'b1; // RQ2
      end
      `GPP_M_INPUT:
      begin
        c.in_en = 1'b1; // RQ3
        c.filter = d; // RQ3
      end
      `GPP_M_INPUT_PULL, `GPP_M_INPUT_PULLED_FILTERED:
      begin
        c.in_en = 1'b1; // RQ4
        c.pull_en = 1'b1; // RQ4
        c.pull_up = d; // RQ4
        c.filter = m[0]; // RQ4
      end
      `GPP_M_PUSH_PULL, `GPP_M_PUSH_PULL_ALT:
      begin
        c.in_en = 1'b1;
        c.oe = 1'b1; // RQ5
        c.out = d; // RQ5
        c.alt = m[0]; // RQ5
      end
      `GPP_M_WIRED_OR, `GPP_M_WIRED_OR_PULLDOWN:
      begin
        c.in_en = 1'b1;
        c.out = 1'b1; // RQ6
        c.oe = d; // RQ6
        c.pull_en = m[0]; // RQ6
        c.pull_up = 1'b0; // RQ6
      end
      default:
      begin
        c.in_en = 1'b1;
        c.out = 1'b0; // RQ7
        c.oe = ~d; // RQ7
        c.filter = m[0]; // RQ7
        c.pull_en = m[1]; // RQ7
        c.pull_up = m[1]; // RQ7
        c.alt = m[2]; // RQ7
      end
    endcase
    return c;
  endfunction

  assign all_modes = {pin_mode_high, pin_mode_low};

  // per-pin decode
  genvar gp;
  generate
    for (gp = 0; gp < 16; gp++)
    begin : g_pin
      assign next_pin[gp] = pin_decode(all_modes[4*gp+:4], output_latch[gp]);
      assign next_in_en[gp] = next_pin[gp].in_en;
    end
  endgenerate

  // registered pad controls
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pin_ctrl <= '0;
    else
      pin_ctrl <= next_pin;
  end

  // input sampling, disabled pins read zero
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pin_input_value <= `GPP_RST_INPUT; // RQ12
    else
      pin_input_value <= pad_in & next_in_en; // RQ12
  end

  // ----------------------------------------------------------------
  // external irq source select
  // ----------------------------------------------------------------

  // line j takes pin j of the selected port, unused codes give zero
  genvar gl;
  generate
    for (gl = 0; gl < 8; gl++)
    begin : g_line
      logic [2:0] sel;
      assign sel = ext_irq_port_low[4*gl+:3];
      assign next_irq[gl] = (sel <= `GPP_SEL_MAX) ?
        ext_port_levels[{sel, 4'(gl)}] : 1'b0; // RQ16
    end
  endgenerate

  // registered irq sources
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ext_irq_src <= 8'h00;
    else
      ext_irq_src <= next_irq; // RQ15
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_wait_one_cycle:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop");

  a_latch_set: // RQ9
    assert property (wr_take && avs_address == `GPP_OFS_SET |=>
      output_latch == ($past(output_latch) | $past(avs_writedata[15:0])))
    else $error("set port wrong");

  a_latch_clear: // RQ10
    assert property (wr_take && avs_address == `GPP_OFS_CLEAR |=>
      output_latch == ($past(output_latch) & ~$past(avs_writedata[15:0])))
    else $error("clear port wrong");

  a_latch_toggle: // RQ11
    assert property (wr_take && avs_address == `GPP_OFS_TOGGLE |=>
      output_latch == ($past(output_latch) ^ $past(avs_writedata[15:0])))
    else $error("toggle port wrong");

  a_lock_sticky: // RQ14
    assert property (1'b1 |=> (unlocked_pins & ~$past(unlocked_pins)) == 16'h0000)
    else $error("locked pin unlocked");

  a_locked_mode_hold: // RQ13
    assert property (!unlocked_pins[0] |=> $stable(pin_mode_low[3:0]))
    else $error("locked mode changed");

  a_push_pull_drive: // RQ5
    assert property (pin_mode_low[3:0] == `GPP_M_PUSH_PULL |=>
      pin_ctrl[0].oe && pin_ctrl[0].out == $past(output_latch[0]))
    else $error("push-pull drive wrong");

  a_open_drain_drive: // RQ7
    assert property (pin_mode_low[3] |=>
      !pin_ctrl[0].out && pin_ctrl[0].oe == !$past(output_latch[0]))
    else $error("open-drain drive wrong");

  a_disabled_input: // RQ2
    assert property (pin_mode_low[3:0] == `GPP_M_DISABLED |=>
      !pin_input_value[0] && pin_ctrl[0].pull_en == $past(output_latch[0]))
    else $error("disabled pin wrong");

  a_irq_port_pick: // RQ16
    assert property (ext_irq_port_low[2:0] == `GPP_SEL_MAX |=>
      ext_irq_src[0] == $past(ext_port_levels[80]))
    else $error("irq port F pick wrong");

endmodule

/* File: test/gpp_pads.sv */
// pad model: resolves each pin level from port drive, pulls and the outside world
`timescale 1ns/1ps
module gpp_pads
  import gpp_pkg::*;
(
  input wire logic core_clk, // clock
  input wire gpp_pin_s [15:0] pin_ctrl, // pad control
  input wire logic [15:0] ext_en, // outside drives pin
  input wire logic [15:0] ext_lvl, // outside level
  output logic [15:0] pad_in // resolved level
);
  logic flip = 1'b0;

  // floating pins change every cycle so a stale level is never seen
  always_ff @(posedge core_clk)
    flip <= ~flip;

  // port driver wins, then outside driver, then pull, else floating
  always_comb
    for (int n = 0; n < 16; n++)
      if (pin_ctrl[n].oe)
        pad_in[n] = pin_ctrl[n].out;
      else if (ext_en[n])
        pad_in[n] = ext_lvl[n];
      else if (pin_ctrl[n].pull_en)
        pad_in[n] = pin_ctrl[n].pull_up;
      else
        pad_in[n] = flip ^ n[0];
endmodule

/* File: test/test_gpp_port.sv */
// self-checking bench for the gpio port block
`timescale 1ns/1ps
`include "gpp_map.svh"
module test_gpp_port import gpp_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] pad_in;
  logic [15:0] ext_en = 16'h0;
  logic [15:0] ext_lvl = 16'h0;
  logic [95:0] ext_port_levels = {16'hffc3, 16'hff0f, 16'hffe1, 16'hff5a, 16'hff96, 16'hff3c};
  gpp_pin_s [15:0] pin_ctrl;
  logic [1:0] port_drive_strength;
  logic [7:0] ext_irq_src;
  logic [31:0] rd;
  logic [31:0] sel;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [8:0] ofs [11] = '{`GPP_OFS_DRIVE, `GPP_OFS_MODE_LOW, `GPP_OFS_MODE_HIGH,
    `GPP_OFS_LATCH, `GPP_OFS_SET, `GPP_OFS_CLEAR, `GPP_OFS_TOGGLE, `GPP_OFS_INPUT,
    `GPP_OFS_UNLOCK, `GPP_OFS_IRQ_SEL, 9'h024};
  logic [31:0] rstv [11] = '{0, 0, 0, 0, 0, 0, 0, 0, 32'h0000ffff, 0, 0};

  gpp_port u_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .pad_in(pad_in),
    .ext_port_levels(ext_port_levels),
    .pin_ctrl(pin_ctrl),
    .port_drive_strength(port_drive_strength),
    .ext_irq_src(ext_irq_src)
  );

  gpp_pads u_pads (
    .core_clk(core_clk),
    .pin_ctrl(pin_ctrl),
    .ext_en(ext_en),
    .ext_lvl(ext_lvl),
    .pad_in(pad_in)
  );

  // clock and hang guard
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low; reserved bits written 0
  task automatic bus_op(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do
    begin
      @(posedge core_clk);
      w++;
    end
    while (avs_waitrequest !== 1'b0 && w < 20);
    rd = avs_readdata;
    check32({31'h0, avs_waitrequest}, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [8:0] a, input logic [31:0] exp);
    bus_op(1'b0, a, 32'h0);
    check32(rd, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // pad control expected for mode m and latch bit l; unset fields masked
  task automatic chkpin(input gpp_pin_s got, input int m, input logic l);
    logic [6:0] e;
    logic [6:0] k;
    e[6] = m != 0;
    e[5] = (m == 4 || m == 5) ? l : (m == 6 || m == 7);
    e[4] = (m == 4 || m == 5) || ((m == 6 || m == 7) && l) || (m > 7 && !l);
    e[3] = (m == 0 && l) || m == 2 || m == 3 || m == 7 || m inside {10, 11, 14, 15};
    e[2] = m == 0 || ((m == 2 || m == 3) && l) || m inside {10, 11, 14, 15};
    e[1] = (m == 1 && l) || m == 3 || (m > 7 && m % 2 == 1);
    e[0] = m == 5 || m > 11;
    k = {1'b1, m > 3, 2'b11, e[3] || m == 0, 2'b11};
    check32({25'h0, got & k}, {25'h0, e & k});
  endtask

  function automatic logic [31:0] exp_irq(input logic [31:0] s);
    logic [31:0] e;
    int c;
    e = 32'h0;
    for (int j = 0; j < 8; j++)
    begin
      c = int'(s[4*j +: 3]);
      if (c < 6)
        e[j] = ext_port_levels[16*c + j];
    end
    return e;
  endfunction

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++)
      rdchk(ofs[i], rstv[i]);
    bus_op(1'b1, `GPP_OFS_DRIVE, 32'h3);
    settle();
    check32({30'h0, port_drive_strength}, 32'h3);
    // every mode on pin 0 and pin 9, latch low then high
    for (int m = 0; m < 16; m++)
      for (int l = 0; l < 2; l++)
      begin
        bus_op(1'b1, `GPP_OFS_MODE_LOW, 32'(m));
        bus_op(1'b1, `GPP_OFS_MODE_HIGH, 32'(m) << 4);
        bus_op(1'b1, `GPP_OFS_LATCH, l ? 32'h00000201 : 32'h0);
        settle();
        chkpin(pin_ctrl[0], m, l[0]);
        chkpin(pin_ctrl[9], m, l[0]);
        rdchk(`GPP_OFS_MODE_HIGH, 32'(m) << 4);
      end
    // latch write and the three bit-wise ports
    bus_op(1'b1, `GPP_OFS_LATCH, 32'h00001234);
    rdchk(`GPP_OFS_LATCH, 32'h00001234);
    bus_op(1'b1, `GPP_OFS_SET, 32'h00008001);
    rdchk(`GPP_OFS_LATCH, 32'h00009235);
    bus_op(1'b1, `GPP_OFS_CLEAR, 32'h00000234);
    rdchk(`GPP_OFS_LATCH, 32'h00009001);
    bus_op(1'b1, `GPP_OFS_TOGGLE, 32'h0000ff00);
    rdchk(`GPP_OFS_LATCH, 32'h00006f01);
    rdchk(`GPP_OFS_TOGGLE, 32'h0);
    // inputs: pins 0-7 sensing, 8-15 disabled
    bus_op(1'b1, `GPP_OFS_MODE_LOW, 32'h11111111);
    bus_op(1'b1, `GPP_OFS_MODE_HIGH, 32'h0);
    ext_en <= 16'hffff;
    ext_lvl <= 16'ha5c3;
    settle();
    rdchk(`GPP_OFS_INPUT, 32'h000000c3);
    // pin 0 push-pull high seen back on the input
    ext_en <= 16'hfffe;
    bus_op(1'b1, `GPP_OFS_MODE_LOW, 32'h00000014);
    settle();
    rdchk(`GPP_OFS_INPUT, 32'h00000003);
    // lock pin 0, then try to change and unlock it
    ext_en <= 16'h0;
    bus_op(1'b1, `GPP_OFS_MODE_LOW, 32'h00000002);
    bus_op(1'b1, `GPP_OFS_UNLOCK, 32'h0000fffe);
    bus_op(1'b1, `GPP_OFS_MODE_LOW, 32'h00000055);
    rdchk(`GPP_OFS_MODE_LOW, 32'h00000052);
    bus_op(1'b1, `GPP_OFS_UNLOCK, 32'h0000ffff);
    rdchk(`GPP_OFS_UNLOCK, 32'h0000fffe);
    // every port code on all lines, then a mixed selection, then it again with levels inverted
    for (int i = 0; i < 10; i++)
    begin
      sel = (i < 8) ? 32'h11111111 * i : 32'h01234567;
      if (i == 9)
        ext_port_levels <= ~ext_port_levels; // irq source must follow the pin levels
      bus_op(1'b1, `GPP_OFS_IRQ_SEL, sel);
      settle();
      check32({24'h0, ext_irq_src}, exp_irq(sel));
      rdchk(`GPP_OFS_IRQ_SEL, sel);
    end
    // a second reset in mid-run undoes the lock and restores reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk(`GPP_OFS_UNLOCK, 32'h0000ffff);
    rdchk(`GPP_OFS_LATCH, 32'h0);
    rdchk(`GPP_OFS_IRQ_SEL, 32'h0);
    bus_op(1'b1, `GPP_OFS_MODE_LOW, 32'h00000005);
    rdchk(`GPP_OFS_MODE_LOW, 32'h00000005);
    give_verdict();
  end
endmodule
